/* File: design/control_link_error_reporter.sv */
`timescale 1ns/100ps
// Operation
// - structureless message answered by bare garbage report
// - unknown command or extension gets unknown report
// - unknown report echoes command and extension words
// - bad field format gets syntax report
// - syntax report echoes command and extension words
// - disallowed field value gets semantic report
// - semantic report echoes command and extension words
// - out-of-sequence message gets protocol report
// - protocol report echoes command and extension words
// - error reports only for received message faults
// - alarm family queries and reports link alarms
// - stream family queries stream error details
// - alarm query answered with alarm definition
// - alarm state: five chars, 0/1/X each
module control_link_error_reporter (
  input  wire logic                mclk,        // 50 MHz clock
  input  wire logic                rst_n,       // async reset
  input  wire clerr_pkg::apb_req_t apb,         // apb request
  output      clerr_pkg::apb_rsp_t rsp,         // apb response
  input  wire clerr_pkg::rx_msg_t  rx,          // parsed received message
  output      logic                rx_ready,    // message can be taken
  output      clerr_pkg::tx_msg_t  tx,          // message to send
  input  wire logic                tx_ready,    // link took tx
  input  wire logic [63:0]         alarm_utc,   // time of alarm state start
  output      logic                accept,      // clean message to act on
  output      logic                stream_query, // stream status wanted
  output      logic                irq          // interrupt level
);

  typedef struct packed {
    clerr_pkg::state_t   fsm;
    clerr_pkg::tx_msg_t  tx;
    logic                rx_ready;
    logic                accept;
    logic                stream_query;
    clerr_pkg::apb_rsp_t rsp;
    logic [1:0]          ctrl;
    logic [7:0]          stat;
    logic [7:0]          mask;
    logic [4:0]          act;
    logic [4:0]          na;
    logic [39:0]         alarm_sent;
    clerr_pkg::fault_t   last;
    logic [15:0]         nfault;
    logic                irq;
  } regs_t;

  regs_t              st_ff;
  regs_t              nxt_st;
  logic               rx_take;
  logic               apb_done;
  clerr_pkg::fault_t  flt;
  clerr_pkg::own_t    own;
  logic [39:0]        alarm_now;
  logic [7:0]         ev;
  logic [7:0]         clr;

  // ==========================================================
  // decoding helpers
  function automatic clerr_pkg::own_t own_kind(input logic [55:0] cmd, input logic [23:0] ext);
    own_kind = clerr_pkg::OWN_NONE;
    if (cmd == clerr_pkg::CMD_ALARM && ext == clerr_pkg::EXT_INF) own_kind = clerr_pkg::OWN_ALARM_INF;
    if (cmd == clerr_pkg::CMD_ALARM && ext == clerr_pkg::EXT_DEF) own_kind = clerr_pkg::OWN_ALARM_DEF;
    if (cmd == clerr_pkg::CMD_STREAM && ext == clerr_pkg::EXT_INF) own_kind = clerr_pkg::OWN_STREAM_INF;
    if (cmd == clerr_pkg::CMD_STREAM && ext == clerr_pkg::EXT_DEF) own_kind = clerr_pkg::OWN_STREAM_DEF;
    if (cmd == clerr_pkg::CMD_REPORT) own_kind = clerr_pkg::OWN_REPORT;
  endfunction

  function automatic logic is_report_ext(input logic [23:0] ext);
    is_report_ext = (ext == clerr_pkg::EXT_GBG) || (ext == clerr_pkg::EXT_UKN) || (ext == clerr_pkg::EXT_SYN)
                 || (ext == clerr_pkg::EXT_SEM) || (ext == clerr_pkg::EXT_PRT);
  endfunction

  // first matching class wins: garbage, unknown, syntax, semantic, protocol
  function automatic clerr_pkg::fault_t classify(input clerr_pkg::rx_msg_t m, input clerr_pkg::own_t k);
    logic own_fields_bad;
    logic own_known;
    own_fields_bad = (k == clerr_pkg::OWN_ALARM_INF || k == clerr_pkg::OWN_STREAM_INF) && (m.nfields != 4'h0);
    own_known      = (k != clerr_pkg::OWN_NONE) && !(k == clerr_pkg::OWN_REPORT && !is_report_ext(m.ext));
    if (!m.framed)                                classify = clerr_pkg::FLT_GBG;
    else if (!(m.known || own_known))             classify = clerr_pkg::FLT_UKN;
    else if (!m.syntax_ok || own_fields_bad)      classify = clerr_pkg::FLT_SYN;
    else if (!m.value_ok)                         classify = clerr_pkg::FLT_SEM;
    else if (!m.seq_ok || k == clerr_pkg::OWN_ALARM_DEF || k == clerr_pkg::OWN_STREAM_DEF)
                                                  classify = clerr_pkg::FLT_PRT;
    else                                          classify = clerr_pkg::FLT_NONE;
  endfunction

  // five status characters, frame format first
  function automatic logic [39:0] alarm_chars(input logic [4:0] act, input logic [4:0] na);
    alarm_chars = '0;
    for (int i = 0; i < 5; i++) begin
      alarm_chars[i*8 +: 8] = na[i] ? clerr_pkg::CH_NA : (act[i] ? clerr_pkg::CH_ON : clerr_pkg::CH_OFF);
    end
  endfunction

  function automatic logic state_ok(input logic [39:0] s);
    state_ok = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (!(s[i*8 +: 8] inside {clerr_pkg::CH_OFF, clerr_pkg::CH_ON, clerr_pkg::CH_NA})) state_ok = 1'b0;
    end
  endfunction

  function automatic clerr_pkg::tx_msg_t make_report(input logic [23:0] kind, input logic [55:0] cmd,
                                                     input logic [23:0] ext);
    make_report         = '0;
    make_report.valid   = 1'b1;
    make_report.cmd     = clerr_pkg::CMD_REPORT;
    make_report.ext     = kind;
    if (kind != clerr_pkg::EXT_GBG) begin
      make_report.nfields = 2'd2;
      make_report.f1_len  = 4'(clerr_pkg::CMD_LEN);
      make_report.f1      = {8'h00, cmd};
      make_report.f2_len  = 4'(clerr_pkg::EXT_LEN);
      make_report.f2      = {40'h0000000000, ext};
    end
  endfunction

  function automatic clerr_pkg::tx_msg_t make_alarm(input logic [39:0] state, input logic [63:0] utc);
    make_alarm         = '0;
    make_alarm.valid   = 1'b1;
    make_alarm.cmd     = clerr_pkg::CMD_ALARM;
    make_alarm.ext     = clerr_pkg::EXT_DEF;
    make_alarm.nfields = 2'd2;
    make_alarm.f1_len  = 4'(clerr_pkg::STATE_LEN);
    make_alarm.f1      = {24'h000000, state};
    make_alarm.f2_len  = 4'(clerr_pkg::UTC_LEN);
    make_alarm.f2      = utc;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    nxt_st              = st_ff;
    nxt_st.accept       = 1'b0;
    nxt_st.stream_query = 1'b0;
    ev                  = '0;
    clr                 = '0;
    own                 = own_kind(rx.cmd, rx.ext);
    flt                 = classify(rx, own);
    alarm_now           = alarm_chars(st_ff.act, st_ff.na);
    rx_take             = rx.valid && st_ff.rx_ready;
    apb_done            = apb.psel && apb.penable && st_ff.rsp.pready;

    // apb: ready in the first access cycle
    nxt_st.rsp.pready  = apb.psel && !apb.penable;
    nxt_st.rsp.pslverr = 1'b0;
    nxt_st.rsp.prdata  = '0;
    if (apb.psel && !apb.penable) begin
      case (apb.paddr)
        clerr_pkg::OFS_CTRL:  nxt_st.rsp.prdata = {30'h00000000, st_ff.ctrl};
        clerr_pkg::OFS_STAT:  nxt_st.rsp.prdata = {24'h000000, st_ff.stat};
        clerr_pkg::OFS_MASK:  nxt_st.rsp.prdata = {24'h000000, st_ff.mask};
        clerr_pkg::OFS_ALARM: nxt_st.rsp.prdata = {19'h00000, st_ff.na, 3'h0, st_ff.act};
        clerr_pkg::OFS_INFO:  nxt_st.rsp.prdata = {st_ff.nfault, 13'h0000, st_ff.last};
        default:              nxt_st.rsp.pslverr = 1'b1;
      endcase
    end
    if (apb_done && apb.pwrite) begin
      case (apb.paddr)
        clerr_pkg::OFS_CTRL:  nxt_st.ctrl = apb.pwdata[1:0];
        clerr_pkg::OFS_MASK:  nxt_st.mask = apb.pwdata[7:0];
        clerr_pkg::OFS_ALARM: begin
          nxt_st.act = apb.pwdata[clerr_pkg::ALARM_ACT +: 5];
          nxt_st.na  = apb.pwdata[clerr_pkg::ALARM_NA +: 5];
        end
        default: ;
      endcase
    end
    if (apb_done && !apb.pwrite && apb.paddr == clerr_pkg::OFS_STAT) begin
      clr = st_ff.rsp.prdata[7:0]; // clear only what the read returned
    end

    // message handling
    case (st_ff.fsm)
      clerr_pkg::ST_IDLE: begin
        if (rx_take) begin
          case (flt)
            clerr_pkg::FLT_GBG: nxt_st.tx = make_report(clerr_pkg::EXT_GBG, '0, '0);
            clerr_pkg::FLT_UKN: nxt_st.tx = make_report(clerr_pkg::EXT_UKN, rx.cmd, rx.ext);
            clerr_pkg::FLT_SYN: nxt_st.tx = make_report(clerr_pkg::EXT_SYN, rx.cmd, rx.ext);
            clerr_pkg::FLT_SEM: nxt_st.tx = make_report(clerr_pkg::EXT_SEM, rx.cmd, rx.ext);
            clerr_pkg::FLT_PRT: nxt_st.tx = make_report(clerr_pkg::EXT_PRT, rx.cmd, rx.ext);
            default: begin
              if (own == clerr_pkg::OWN_ALARM_INF) begin
                nxt_st.tx         = make_alarm(alarm_now, alarm_utc);
                nxt_st.alarm_sent = alarm_now;
                ev[clerr_pkg::EV_ALARM] = 1'b1;
              end else if (own == clerr_pkg::OWN_STREAM_INF) begin
                nxt_st.stream_query        = 1'b1;
                ev[clerr_pkg::EV_STREAM]   = 1'b1;
              end else begin
                nxt_st.accept            = 1'b1;
                ev[clerr_pkg::EV_ACCEPT] = 1'b1;
              end
            end
          endcase
          if (flt != clerr_pkg::FLT_NONE) begin
            ev[3'(flt) - 3'd1] = 1'b1;
            nxt_st.last        = flt;
            nxt_st.nfault      = st_ff.nfault + 16'h0001;
            nxt_st.tx.valid    = st_ff.ctrl[clerr_pkg::CTRL_REPORT];
          end else if (own != clerr_pkg::OWN_ALARM_INF) begin
            nxt_st.tx.valid = 1'b0;
          end
        end else if (st_ff.ctrl[clerr_pkg::CTRL_AUTO] && alarm_now != st_ff.alarm_sent) begin
          nxt_st.tx         = make_alarm(alarm_now, alarm_utc);
          nxt_st.alarm_sent = alarm_now;
        end
        if (nxt_st.tx.valid) begin
          nxt_st.fsm = clerr_pkg::ST_SEND;
        end
      end
      clerr_pkg::ST_SEND: begin
        if (tx_ready) begin
          nxt_st.tx.valid = 1'b0;
          nxt_st.fsm      = clerr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st.tx.valid = 1'b0;
        nxt_st.fsm      = clerr_pkg::ST_IDLE;
      end
    endcase
    nxt_st.rx_ready = (nxt_st.fsm == clerr_pkg::ST_IDLE);

    // sticky events: a new event beats the read clear
    nxt_st.stat = (st_ff.stat & ~clr) | ev;
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff            <= '0;
      st_ff.fsm        <= clerr_pkg::ST_IDLE;
      st_ff.ctrl       <= clerr_pkg::CTRL_RST;
      st_ff.act        <= clerr_pkg::ACT_RST;
      st_ff.na         <= clerr_pkg::NA_RST;
      st_ff.last       <= clerr_pkg::FLT_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp          = st_ff.rsp;
  assign rx_ready     = st_ff.rx_ready;
  assign tx           = st_ff.tx;
  assign accept       = st_ff.accept;
  assign stream_query = st_ff.stream_query;
  assign irq          = st_ff.irq;

  // ==========================================================
  // checks
  gbg_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && !rx.framed && st_ff.ctrl[clerr_pkg::CTRL_REPORT])
    |=> (tx.valid && tx.cmd == clerr_pkg::CMD_REPORT && tx.ext == clerr_pkg::EXT_GBG && tx.nfields == 2'd0))
    else $error("garbage message not answered by bare report");

  ukn_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && rx.framed && !rx.known && own_kind(rx.cmd, rx.ext) == clerr_pkg::OWN_NONE
     && st_ff.ctrl[clerr_pkg::CTRL_REPORT]) |=> (tx.valid && tx.ext == clerr_pkg::EXT_UKN))
    else $error("unknown command not reported");

  echo_fields_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt inside {clerr_pkg::FLT_UKN, clerr_pkg::FLT_SYN, clerr_pkg::FLT_SEM, clerr_pkg::FLT_PRT}
     && st_ff.ctrl[clerr_pkg::CTRL_REPORT])
    |=> (tx.f1 == {8'h00, $past(rx.cmd)} && tx.f2[23:0] == $past(rx.ext) && tx.f1_len == 4'd7 && tx.f2_len == 4'd3))
    else $error("report does not echo command and extension");

  syn_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && rx.framed && rx.known && !rx.syntax_ok && st_ff.ctrl[clerr_pkg::CTRL_REPORT])
    |=> (tx.valid && tx.ext == clerr_pkg::EXT_SYN && tx.nfields == 2'd2))
    else $error("syntax fault not reported");

  sem_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt == clerr_pkg::FLT_SEM && st_ff.ctrl[clerr_pkg::CTRL_REPORT])
    |=> (tx.valid && tx.ext == clerr_pkg::EXT_SEM && tx.f1[55:0] == $past(rx.cmd)))
    else $error("semantic fault not reported");

  prt_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && rx.framed && rx.known && rx.syntax_ok && rx.value_ok && !rx.seq_ok
     && st_ff.ctrl[clerr_pkg::CTRL_REPORT]) |=> (tx.valid && tx.ext == clerr_pkg::EXT_PRT))
    else $error("protocol fault not reported");

  err_family_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx.valid && tx.cmd == clerr_pkg::CMD_REPORT) |-> (is_report_ext(tx.ext) && st_ff.last != clerr_pkg::FLT_NONE))
    else $error("error report without a received fault");

  alarm_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt == clerr_pkg::FLT_NONE && own == clerr_pkg::OWN_ALARM_INF)
    |=> (tx.valid && tx.cmd == clerr_pkg::CMD_ALARM && tx.ext == clerr_pkg::EXT_DEF && tx.f1_len == 4'd5
         && tx.f1[39:0] == alarm_chars($past(st_ff.act), $past(st_ff.na))))
    else $error("alarm query not answered with alarm state");

  one_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && !rx.framed && !rx.syntax_ok && !rx.seq_ok && st_ff.ctrl[clerr_pkg::CTRL_REPORT])
    |=> (st_ff.last == clerr_pkg::FLT_GBG && !rx_ready && st_ff.nfault == $past(st_ff.nfault) + 16'h0001))
    else $error("fault priority or single report broken");

  no_act_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt != clerr_pkg::FLT_NONE) |=> (!accept && !stream_query))
    else $error("faulty message was acted upon");

  tx_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx.valid && !tx_ready) |=> (tx.valid && $stable(tx.ext) && $stable(tx.f1)))
    else $error("outgoing message dropped before taken");

  stream_query_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt == clerr_pkg::FLT_NONE && own == clerr_pkg::OWN_STREAM_INF) |=> (stream_query && !tx.valid))
    else $error("stream query not passed on");

  accept_clean_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt == clerr_pkg::FLT_NONE && !(own inside {clerr_pkg::OWN_ALARM_INF, clerr_pkg::OWN_STREAM_INF}))
    |=> (accept && !tx.valid))
    else $error("clean message not passed on");

  report_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_take && flt != clerr_pkg::FLT_NONE && !st_ff.ctrl[clerr_pkg::CTRL_REPORT]) |=> (!tx.valid && rx_ready))
    else $error("report sent while reports are off");

  alarm_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx.valid && tx.cmd == clerr_pkg::CMD_ALARM)
    |-> (tx.ext == clerr_pkg::EXT_DEF && tx.f1_len == 4'h5 && tx.f2_len == 4'h8 && state_ok(tx.f1[39:0])))
    else $error("alarm state field malformed");

  rx_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx.valid |-> !rx_ready)
    else $error("new message taken while a reply is pending");

  apb_ready_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (apb.psel && !apb.penable) |=> (rsp.pready ##1 !rsp.pready))
    else $error("apb ready not a single pulse after setup");

  stat_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (apb_done && !apb.pwrite && apb.paddr == clerr_pkg::OFS_STAT)
    |=> ((st_ff.stat & $past(rsp.prdata[7:0]) & ~$past(ev)) == 8'h00))
    else $error("status read did not clear the reported bits");

endmodule

/* File: design/clerr_pkg.sv */
package clerr_pkg;

  // ==========================================================
  // character strings
  typedef logic [7:0] char_t;
  localparam int unsigned CMD_LEN   = 7;
  localparam int unsigned EXT_LEN   = 3;
  localparam int unsigned STATE_LEN = 5;
  localparam int unsigned UTC_LEN   = 8;
  localparam int unsigned FLD_LEN   = 8;

  localparam logic [55:0] CMD_REPORT  = "PRERROR";
  localparam logic [55:0] CMD_ALARM   = "ALARMST";
  localparam logic [55:0] CMD_STREAM  = "STERROR";
  localparam logic [23:0] EXT_GBG     = "GBG";
  localparam logic [23:0] EXT_UKN     = "UKN";
  localparam logic [23:0] EXT_SYN     = "SYN";
  localparam logic [23:0] EXT_SEM     = "SEM";
  localparam logic [23:0] EXT_PRT     = "PRT";
  localparam logic [23:0] EXT_INF     = "INF";
  localparam logic [23:0] EXT_DEF     = "DEF";
  localparam char_t       CH_OFF      = 8'h30;
  localparam char_t       CH_ON       = 8'h31;
  localparam char_t       CH_NA       = 8'h58;

  // ==========================================================
  // register map
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STAT    = 8'h04;
  localparam logic [7:0]  OFS_MASK    = 8'h08;
  localparam logic [7:0]  OFS_ALARM   = 8'h0C;
  localparam logic [7:0]  OFS_INFO    = 8'h10;
  localparam int unsigned CTRL_REPORT = 0;
  localparam int unsigned CTRL_AUTO   = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h1;
  localparam int unsigned ALARM_ACT   = 0;
  localparam int unsigned ALARM_NA    = 8;
  localparam logic [4:0]  ACT_RST     = 5'h00;
  localparam logic [4:0]  NA_RST      = 5'h1F;
  localparam int unsigned INFO_CNT    = 16;
  localparam int unsigned EV_GBG      = 0;
  localparam int unsigned EV_UKN      = 1;
  localparam int unsigned EV_SYN      = 2;
  localparam int unsigned EV_SEM      = 3;
  localparam int unsigned EV_PRT      = 4;
  localparam int unsigned EV_ALARM    = 5;
  localparam int unsigned EV_STREAM   = 6;
  localparam int unsigned EV_ACCEPT   = 7;
  localparam int unsigned N_EV        = 8;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    FLT_NONE = 3'h0, FLT_GBG = 3'h1, FLT_UKN = 3'h2, FLT_SYN = 3'h3, FLT_SEM = 3'h4, FLT_PRT = 3'h5
  } fault_t;

  typedef enum logic [2:0] {
    OWN_NONE = 3'h0, OWN_ALARM_INF = 3'h1, OWN_ALARM_DEF = 3'h2, OWN_STREAM_INF = 3'h3,
    OWN_STREAM_DEF = 3'h4, OWN_REPORT = 3'h5
  } own_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01} state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        framed;
    logic        known;
    logic        syntax_ok;
    logic        value_ok;
    logic        seq_ok;
    logic [3:0]  nfields;
    logic [55:0] cmd;
    logic [23:0] ext;
  } rx_msg_t;

  typedef struct packed {
    logic        valid;
    logic [55:0] cmd;
    logic [23:0] ext;
    logic [1:0]  nfields;
    logic [3:0]  f1_len;
    logic [63:0] f1;
    logic [3:0]  f2_len;
    logic [63:0] f2;
  } tx_msg_t;

endpackage

/* File: tb/remote_entity_model.sv */
`timescale 1ns/100ps
module remote_entity_model (
  input  wire logic               mclk,     // clock
  input  wire logic               rst_n,    // async reset
  input  wire logic               rx_ready, // block can take rx
  input  wire clerr_pkg::tx_msg_t tx,       // message from block
  input  wire logic [7:0]         stall,    // cycles before taking tx
  output      clerr_pkg::rx_msg_t rx,       // message to block
  output      logic               tx_ready, // tx taken at this edge
  output      clerr_pkg::tx_msg_t got,      // last message taken
  output      logic [15:0]        n_got     // messages taken
);
  logic [7:0] wait_cnt;

  initial rx = '0;

  // ==========================================================
  // present one message, hold it until taken, then scramble
  task automatic send(input clerr_pkg::rx_msg_t m);
    clerr_pkg::rx_msg_t idle;
    rx <= m;
    do @(posedge mclk); while (rx_ready !== 1'b1);
    idle = ~m;
    idle.valid = 1'b0;
    rx <= idle;
  endtask

  // ==========================================================
  // take replies after a settable stall, never answer reports
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      wait_cnt <= 8'h00;
      n_got    <= 16'h0000;
      got      <= '0;
    end else if (tx_ready && tx.valid) begin
      got      <= tx;
      n_got    <= n_got + 16'h0001;
      tx_ready <= 1'b0;
      wait_cnt <= 8'h00;
    end else if (tx.valid) begin
      if (wait_cnt >= stall) tx_ready <= 1'b1;
      else wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule

/* File: tb/control_link_error_reporter_test.sv */
`timescale 1ns/100ps
module control_link_error_reporter_test;
  typedef struct packed {
    clerr_pkg::rx_msg_t m;
    logic [23:0]        eext;
    logic [7:0]         estat;
  } row_t;

  logic                mclk, rst_n, rx_ready, tx_ready, accept, stream_query, irq, err;
  clerr_pkg::apb_req_t apb;
  clerr_pkg::apb_rsp_t rsp;
  clerr_pkg::rx_msg_t  rx;
  clerr_pkg::tx_msg_t  tx, got;
  logic [63:0]         utc, exp_state;
  logic [31:0]         q;
  logic [15:0]         n_got, g0;
  logic [7:0]          stall;
  int                  miscompares, checks_done, acc_cnt, sq_cnt, a0, s0;
  row_t                rows [10];

  control_link_error_reporter control_link_error_reporter_inst (
    .mclk(mclk), .rst_n(rst_n), .apb(apb), .rsp(rsp), .rx(rx), .rx_ready(rx_ready), .tx(tx),
    .tx_ready(tx_ready), .alarm_utc(utc), .accept(accept), .stream_query(stream_query), .irq(irq));
  remote_entity_model remote_entity_model_inst (
    .mclk(mclk), .rst_n(rst_n), .rx_ready(rx_ready), .tx(tx), .stall(stall), .rx(rx),
    .tx_ready(tx_ready), .got(got), .n_got(n_got));

  // ==========================================================
  // clock, pulse counters, watchdog
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (accept === 1'b1) acc_cnt++;
    if (stream_query === 1'b1) sq_cnt++;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apb.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wait_reply();
    while (n_got == g0) @(posedge mclk);
  endtask

  task automatic check_tx(input clerr_pkg::rx_msg_t m, input logic [23:0] e);
    logic al;
    al = (e == clerr_pkg::EXT_DEF);
    chk(got.cmd, al ? clerr_pkg::CMD_ALARM : clerr_pkg::CMD_REPORT);
    chk(got.ext, e);
    chk(got.nfields, (e == clerr_pkg::EXT_GBG) ? 2'h0 : 2'h2);
    if (e != clerr_pkg::EXT_GBG) begin
      chk(got.f1_len, al ? 4'h5 : 4'h7);
      chk(got.f1, al ? exp_state : {8'h00, m.cmd});
      chk(got.f2_len, al ? 4'h8 : 4'h3);
      chk(got.f2, al ? utc : {40'h0, m.ext});
    end
  endtask

  function automatic clerr_pkg::rx_msg_t mk(input logic [55:0] c, input logic [23:0] e, input logic [4:0] f);
    mk = '{valid: 1'b1, framed: f[4], known: f[3], syntax_ok: f[2], value_ok: f[1], seq_ok: f[0],
           nfields: 4'h0, cmd: c, ext: e};
  endfunction

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    apb = '0;
    stall = 8'h00;
    utc = "12:34:56";
    exp_state = {24'h0, "XXXXX"};
    rows[0] = '{mk("NETCONF", "DEF", 5'b01010), clerr_pkg::EXT_GBG, 8'h01};
    rows[1] = '{mk("ZZZZZZZ", "QQQ", 5'b10111), clerr_pkg::EXT_UKN, 8'h02};
    rows[2] = '{mk("NETCONF", "DEF", 5'b11011), clerr_pkg::EXT_SYN, 8'h04};
    rows[3] = '{mk("NETCONF", "REC", 5'b11101), clerr_pkg::EXT_SEM, 8'h08};
    rows[4] = '{mk("ZZZZZZZ", "DEF", 5'b10010), clerr_pkg::EXT_UKN, 8'h02};
    rows[5] = '{mk("NETCONF", "END", 5'b11000), clerr_pkg::EXT_SYN, 8'h04};
    rows[6] = '{mk("NETCONF", "DEF", 5'b11110), clerr_pkg::EXT_PRT, 8'h10};
    rows[7] = '{mk(clerr_pkg::CMD_ALARM, "INF", 5'b11111), clerr_pkg::EXT_DEF, 8'h20};
    rows[8] = '{mk(clerr_pkg::CMD_STREAM, "INF", 5'b11111), 24'h0, 8'h40};
    rows[9] = '{mk("NETCONF", "END", 5'b11111), 24'h0, 8'h80};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb_xfer(1'b1, clerr_pkg::OFS_MASK, 32'hFF);
    for (int i = 0; i < 10; i++) begin
      g0 = n_got;
      a0 = acc_cnt;
      s0 = sq_cnt;
      remote_entity_model_inst.send(rows[i].m);
      if (rows[i].eext != 24'h0) wait_reply();
      repeat (4) @(posedge mclk);
      chk(n_got - g0, {63'h0, rows[i].eext != 24'h0});
      chk(acc_cnt - a0, {63'h0, rows[i].estat == 8'h80});
      chk(sq_cnt - s0, {63'h0, rows[i].estat == 8'h40});
      if (rows[i].eext != 24'h0) check_tx(rows[i].m, rows[i].eext);
      chk(irq, 1'b1);
      rd(clerr_pkg::OFS_STAT, {24'h0, rows[i].estat});
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
    end
    rd(clerr_pkg::OFS_INFO, {16'h7, 16'h5});
    // slow partner, alarm string built from the register
    apb_xfer(1'b1, clerr_pkg::OFS_ALARM, 32'h0110);
    exp_state = {24'h0, "1000X"};
    stall <= 8'h03;
    g0 = n_got;
    remote_entity_model_inst.send(rows[7].m);
    repeat (2) @(posedge mclk);
    chk(rx_ready, 1'b0);
    wait_reply();
    check_tx(rows[7].m, clerr_pkg::EXT_DEF);
    stall <= 8'h00;
    // reports off, interrupt masked
    apb_xfer(1'b1, clerr_pkg::OFS_MASK, 32'h0);
    apb_xfer(1'b1, clerr_pkg::OFS_CTRL, 32'h0);
    g0 = n_got;
    remote_entity_model_inst.send(rows[0].m);
    repeat (4) @(posedge mclk);
    chk(n_got - g0, 64'h0);
    chk(irq, 1'b0);
    rd(clerr_pkg::OFS_STAT, 32'h21);
    rd(8'h14, 32'h0);
    chk(err, 1'b1);
    // automatic alarm report on change
    g0 = n_got;
    exp_state = {24'h0, "00000"};
    apb_xfer(1'b1, clerr_pkg::OFS_CTRL, 32'h2);
    apb_xfer(1'b1, clerr_pkg::OFS_ALARM, 32'h0);
    wait_reply();
    check_tx(rows[7].m, clerr_pkg::EXT_DEF);
    // second reset mid-run
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    chk(rx_ready, 1'b1);
    rd(clerr_pkg::OFS_CTRL, 32'h1);
    rd(clerr_pkg::OFS_MASK, 32'h0);
    rd(clerr_pkg::OFS_ALARM, 32'h1F00);
    rd(clerr_pkg::OFS_INFO, 32'h0);
    test_done();
  end
endmodule
